/* File: common/sensor_acq_pkg.sv */
package sensor_acq_pkg;

    // Register port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // Register offsets, word addressed
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h03;
    localparam logic [ADDR_W-1:0] OFF_ACQ = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_GLB = 8'h05;
    localparam logic [ADDR_W-1:0] OFF_STAT = 8'h06;

    // Reset values and writable masks
    localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] ACQ_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] GLB_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] CTRL_MASK = 16'h003f;
    localparam logic [DATA_W-1:0] ACQ_MASK = 16'h07fc;
    localparam logic [DATA_W-1:0] GLB_MASK = 16'h05fd;
    localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

    // Chip control fields
    localparam int CTRL_RUN = 0;
    localparam int CTRL_REC = 1;
    localparam int CTRL_AUTO_START = 3;
    localparam int CTRL_QUICK = 4;
    localparam int CTRL_XE = 5;
    localparam int CTRL_SRST = 15;

    // Acquisition configuration fields
    localparam int ACQ_BDIV = 2;
    localparam int ACQ_ADIV = 4;
    localparam int ACQ_IDIV = 6;
    localparam int ACQ_DOZE = 8;
    localparam int ACQ_BARM = 9;
    localparam int ACQ_AARM = 10;

    // Global settings fields
    localparam int GLB_LAMP = 0;
    localparam int GLB_ABIN = 2;
    localparam int GLB_BBIN = 3;
    localparam int GLB_ASUB = 4;

    // Clock division codes and divider counter limits
    localparam logic [1:0] DIV_1 = 2'h0;
    localparam logic [1:0] DIV_2 = 2'h1;
    localparam logic [1:0] DIV_4 = 2'h2;
    localparam logic [1:0] LIM_1 = 2'h0;
    localparam logic [1:0] LIM_2 = 2'h1;
    localparam logic [1:0] LIM_4 = 2'h3;

    // Divided clock ticks per frame
    localparam logic [15:0] FRAME_TICKS = 16'h0040;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_HALT = 2'b10
    } acq_state_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_s;

endpackage

/* File: hdl/div_enable.sv */
`timescale 1ns/10ps
module div_enable (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Division code
    input wire logic [1:0] code,
    // One-cycle enable at the divided rate
    output logic tick
);
    logic [1:0] cnt_reg, cnt_next;
    logic [1:0] limit;
    logic tick_reg, tick_next;

    // Invalid code falls back to divide by one
    always_comb begin
        case (code)
            sensor_acq_pkg::DIV_2: limit = sensor_acq_pkg::LIM_2;
            sensor_acq_pkg::DIV_4: limit = sensor_acq_pkg::LIM_4;
            default: limit = sensor_acq_pkg::LIM_1;
        endcase
        tick_next = (cnt_reg >= limit);
        cnt_next = tick_next ? 2'h0 : 2'(cnt_reg + 2'h1);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 2'h0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;

    div_full_a: assert property (@(posedge clk) disable iff (!rst_n)
        (code == sensor_acq_pkg::DIV_1 || code == 2'h3) |=> tick)
        else $error("Divide by one missed a tick");
    div_quarter_a: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && code == sensor_acq_pkg::DIV_4) ##1 (code == sensor_acq_pkg::DIV_4)[*3]
        |-> !tick && $past(!tick) && $past(!tick, 2) ##1 tick)
        else $error("Divide by four spacing wrong");
endmodule

/* File: hdl/frame_timer.sv */
`timescale 1ns/10ps
module frame_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic clear,
    input wire logic tick,
    // Frame completion pulse
    output logic frame_end
);
    logic [15:0] cnt_reg, cnt_next;
    logic end_reg, end_next;

    // Counts divided ticks; a clear restarts the frame
    always_comb begin
        cnt_next = cnt_reg;
        end_next = 1'b0;
        if (clear) begin
            cnt_next = 16'h0000;
        end else if (tick) begin
            if (cnt_reg == 16'(sensor_acq_pkg::FRAME_TICKS - 16'h0001)) begin
                cnt_next = 16'h0000;
                end_next = 1'b1;
            end else begin
                cnt_next = 16'(cnt_reg + 16'h0001);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 16'h0000;
            end_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            end_reg <= end_next;
        end
    end

    assign frame_end = end_reg;
endmodule

/* File: hdl/sensor_acquisition_control.sv */
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
module sensor_acquisition_control (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port
    input sensor_acq_pkg::reg_req_s reg_req,
    output logic [sensor_acq_pkg::DATA_W-1:0] rd_data,
    // Acquisition status
    output logic acq_running,
    output logic active_record,
    output logic pixel_tick,
    output logic frame_done,
    // Flash and power
    output logic xenon_fire,
    output logic lamp_flash,
    output logic sequencer_doze_signal,
    // Readout shaping
    output logic bin_enable,
    output logic [1:0] record_a_subsample
);
    logic rst_sync1_reg, rst_n;
    logic [15:0] ctrl_reg, ctrl_next;
    logic [15:0] acq_reg, acq_next;
    logic [15:0] glb_reg, glb_next;
    logic [15:0] rd_reg, rd_next;
    sensor_acq_pkg::acq_state_e state_reg, state_next;
    logic pend_reg, pend_next;
    logic rec_reg, rec_next;
    logic run_reg, run_next;
    logic xe_reg, xe_next;
    logic doze_reg, doze_next;
    logic bin_reg, bin_next;
    logic ctrl_wr, acq_wr, glb_wr;
    logic wr_run, wr_auto, wr_quick, wr_srst;
    logic start_req, stop_req, start_go;
    logic [1:0] div_sel;
    logic tick, frame_end;

    // Release the asynchronous reset through two flip-flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync1_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_n <= rst_sync1_reg;
        end
    end

    // Write decode and fields of the incoming control word
    assign ctrl_wr = reg_req.wr && (reg_req.addr == sensor_acq_pkg::OFF_CTRL);
    assign acq_wr = reg_req.wr && (reg_req.addr == sensor_acq_pkg::OFF_ACQ);
    assign glb_wr = reg_req.wr && (reg_req.addr == sensor_acq_pkg::OFF_GLB);
    assign wr_run = reg_req.wdata[sensor_acq_pkg::CTRL_RUN];
    assign wr_auto = reg_req.wdata[sensor_acq_pkg::CTRL_AUTO_START];
    assign wr_quick = reg_req.wdata[sensor_acq_pkg::CTRL_QUICK];
    assign wr_srst = reg_req.wdata[sensor_acq_pkg::CTRL_SRST];

    // A run edge, or run held with auto start, restarts; any other control write stops
    assign start_req = ctrl_wr && !wr_srst && wr_run
        && (!ctrl_reg[sensor_acq_pkg::CTRL_RUN] || wr_auto);
    assign stop_req = ctrl_wr && !wr_srst && !start_req;

    // Divider for the present phase; idle has its own setting
    always_comb begin
        if (state_reg == sensor_acq_pkg::ST_IDLE) begin
            div_sel = acq_reg[sensor_acq_pkg::ACQ_IDIV +: 2];
        end else if (rec_reg) begin
            div_sel = acq_reg[sensor_acq_pkg::ACQ_BDIV +: 2];
        end else begin
            div_sel = acq_reg[sensor_acq_pkg::ACQ_ADIV +: 2];
        end
    end

    div_enable u_div (
        .clk(clk),
        .rst_n(rst_n),
        .code(div_sel),
        .tick(tick)
    );

    frame_timer u_frame (
        .clk(clk),
        .rst_n(rst_n),
        .clear(start_go || (state_reg == sensor_acq_pkg::ST_IDLE)),
        .tick(tick),
        .frame_end(frame_end)
    );

    // Register writes and acquisition sequencing
    always_comb begin
        ctrl_next = ctrl_reg;
        acq_next = acq_reg;
        glb_next = glb_reg;
        state_next = state_reg;
        pend_next = pend_reg;
        rec_next = rec_reg;
        start_go = 1'b0;
        if (ctrl_wr) begin
            // Soft reset leaves the other registers alone
            ctrl_next = wr_srst ? sensor_acq_pkg::CTRL_RESET
                : (reg_req.wdata & sensor_acq_pkg::CTRL_MASK);
        end
        if (acq_wr) begin
            acq_next = reg_req.wdata & sensor_acq_pkg::ACQ_MASK;
        end
        if (glb_wr) begin
            glb_next = reg_req.wdata & sensor_acq_pkg::GLB_MASK;
        end
        case (state_reg)
            sensor_acq_pkg::ST_IDLE: begin
                start_go = start_req;
            end
            sensor_acq_pkg::ST_RUN, sensor_acq_pkg::ST_HALT: begin
                if (start_req || stop_req) begin
                    if (wr_quick) begin
                        start_go = start_req;
                        pend_next = 1'b0;
                        if (!start_req) begin
                            state_next = sensor_acq_pkg::ST_IDLE;
                        end
                    end else begin
                        // Latest request wins while the frame drains
                        state_next = sensor_acq_pkg::ST_HALT;
                        pend_next = start_req;
                    end
                end else if (state_reg == sensor_acq_pkg::ST_HALT && frame_end) begin
                    start_go = pend_reg;
                    pend_next = 1'b0;
                    if (!pend_reg) begin
                        state_next = sensor_acq_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                state_next = sensor_acq_pkg::ST_IDLE;
                pend_next = 1'b0;
            end
        endcase
        if (ctrl_wr && wr_srst) begin
            // Soft reset drops any acquisition outright
            start_go = 1'b0;
            pend_next = 1'b0;
            state_next = sensor_acq_pkg::ST_IDLE;
        end
        if (start_go) begin
            state_next = sensor_acq_pkg::ST_RUN;
            rec_next = ctrl_next[sensor_acq_pkg::CTRL_REC];
        end
    end

    // Flag outputs derived from the next state
    always_comb begin
        run_next = (state_next != sensor_acq_pkg::ST_IDLE);
        xe_next = start_go && ctrl_next[sensor_acq_pkg::CTRL_XE]
            && (rec_next ? acq_reg[sensor_acq_pkg::ACQ_BARM]
                : acq_reg[sensor_acq_pkg::ACQ_AARM]);
        doze_next = (state_next == sensor_acq_pkg::ST_IDLE)
            && acq_next[sensor_acq_pkg::ACQ_DOZE];
        bin_next = rec_next ? glb_next[sensor_acq_pkg::GLB_BBIN]
            : glb_next[sensor_acq_pkg::GLB_ABIN];
    end

    // Read mux; unmapped offsets and idle cycles return zero
    always_comb begin
        rd_next = sensor_acq_pkg::ZERO_WORD;
        if (reg_req.rd) begin
            case (reg_req.addr)
                sensor_acq_pkg::OFF_CTRL: rd_next = ctrl_reg;
                sensor_acq_pkg::OFF_ACQ: rd_next = acq_reg;
                sensor_acq_pkg::OFF_GLB: rd_next = glb_reg;
                sensor_acq_pkg::OFF_STAT: rd_next = {11'h000, doze_reg, div_sel, rec_reg, run_reg};
                default: rd_next = sensor_acq_pkg::ZERO_WORD;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= sensor_acq_pkg::CTRL_RESET;
            acq_reg <= sensor_acq_pkg::ACQ_RESET;
            glb_reg <= sensor_acq_pkg::GLB_RESET;
            rd_reg <= sensor_acq_pkg::ZERO_WORD;
            state_reg <= sensor_acq_pkg::ST_IDLE;
            pend_reg <= 1'b0;
            rec_reg <= 1'b0;
            run_reg <= 1'b0;
            xe_reg <= 1'b0;
            doze_reg <= 1'b0;
            bin_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            acq_reg <= acq_next;
            glb_reg <= glb_next;
            rd_reg <= rd_next;
            state_reg <= state_next;
            pend_reg <= pend_next;
            rec_reg <= rec_next;
            run_reg <= run_next;
            xe_reg <= xe_next;
            doze_reg <= doze_next;
            bin_reg <= bin_next;
        end
    end

    // Outputs straight from flip-flops
    assign rd_data = rd_reg;
    assign acq_running = run_reg;
    assign active_record = rec_reg;
    assign pixel_tick = tick;
    assign frame_done = frame_end;
    assign xenon_fire = xe_reg;
    // The lamp is switched with no regard to frame timing
    assign lamp_flash = glb_reg[sensor_acq_pkg::GLB_LAMP];
    assign sequencer_doze_signal = doze_reg;
    assign bin_enable = bin_reg;
    assign record_a_subsample = glb_reg[sensor_acq_pkg::GLB_ASUB +: 2];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence ctrl_write_s(logic run, logic quick);
        ctrl_wr && !wr_srst && wr_run == run && wr_quick == quick;
    endsequence

    sequence slow_stop_s;
        state_reg == sensor_acq_pkg::ST_RUN ##0 ctrl_write_s(1'b0, 1'b0);
    endsequence

    halt_wait_a: assert property (slow_stop_s |=> state_reg == sensor_acq_pkg::ST_HALT
        && run_reg)
        else $error("Stop did not wait for frame end");
    halt_hold_a: assert property (state_reg == sensor_acq_pkg::ST_HALT && !frame_end
        && !ctrl_wr |=> state_reg == sensor_acq_pkg::ST_HALT)
        else $error("Halt left before frame end");
    quick_abort_a: assert property (state_reg != sensor_acq_pkg::ST_IDLE
        ##0 ctrl_write_s(1'b0, 1'b1) |=> !run_reg ##0 state_reg == sensor_acq_pkg::ST_IDLE)
        else $error("Quick stop did not abort");
    xenon_cause_a: assert property (xenon_fire |-> $past(start_go)
        && $past(ctrl_next[sensor_acq_pkg::CTRL_XE]))
        else $error("Xenon fired without start and enable");
    xenon_arm_a: assert property (start_go && ctrl_next[sensor_acq_pkg::CTRL_XE] &&
        !rec_next && acq_reg[sensor_acq_pkg::ACQ_AARM]
        |=> xenon_fire ##1 (!xenon_fire || $past(start_go)))
        else $error("Armed record A start did not fire once");
    xenon_b_a: assert property (start_go && ctrl_next[sensor_acq_pkg::CTRL_XE] &&
        rec_next && acq_reg[sensor_acq_pkg::ACQ_BARM] |=> xenon_fire)
        else $error("Armed record B start did not fire");
    soft_reset_a: assert property (ctrl_wr && wr_srst |=> ctrl_reg == 16'h0000
        && $stable(acq_reg) && $stable(glb_reg) && !run_reg)
        else $error("Soft reset wrong");
    doze_idle_a: assert property (!run_reg && acq_reg[sensor_acq_pkg::ACQ_DOZE]
        && $stable(acq_reg) |-> sequencer_doze_signal)
        else $error("Doze not shown while idle");
    doze_run_a: assert property (run_reg |-> !sequencer_doze_signal)
        else $error("Doze shown while running");
    lamp_follow_a: assert property (glb_wr |=> lamp_flash
        == $past(reg_req.wdata[sensor_acq_pkg::GLB_LAMP]))
        else $error("Lamp does not follow write");
    restart_a: assert property (state_reg == sensor_acq_pkg::ST_IDLE
        ##0 ctrl_write_s(1'b1, 1'b0) ##0 !ctrl_reg[sensor_acq_pkg::CTRL_RUN]
        |=> run_reg && active_record == $past(reg_req.wdata[sensor_acq_pkg::CTRL_REC]))
        else $error("Run edge did not start in chosen record");
    unused_zero_a: assert property (reg_req.rd && reg_req.addr == sensor_acq_pkg::OFF_CTRL
        |=> rd_data[15:6] == 10'h000)
        else $error("Unused control bits read nonzero");
    // Binning must track the record even while idle
    bin_pick_a: assert property (bin_enable == (active_record
        ? glb_reg[sensor_acq_pkg::GLB_BBIN] : glb_reg[sensor_acq_pkg::GLB_ABIN]))
        else $error("Binning does not follow record");
    div_pick_a: assert property (state_reg == sensor_acq_pkg::ST_RUN && rec_reg
        |-> div_sel == acq_reg[sensor_acq_pkg::ACQ_BDIV +: 2])
        else $error("Record B divider not applied");
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    sensor_acq_pkg::reg_req_s reg_req = '0;
    logic [15:0] rd_data;
    logic acq_running, active_record, pixel_tick, frame_done;
    logic xenon_fire, lamp_flash, doze, bin_enable;
    logic [1:0] record_a_subsample;
    int num_errors = 0;
    int cmp_count = 0;
    int k;
    logic [15:0] exp_q[$];
    logic rd_v = 1'b0;
    logic [31:0] seed = 32'hf8e5c7e8;
    logic [1:0] da, db, di;
    logic [47:0] xtab [4] = '{48'h0400_0021_0001, 48'h0400_0023_0000,
                              48'h0200_0023_0001, 48'h0200_0003_0000};

    // Free-running 10 MHz clock
    always #50 clk = ~clk;

    sensor_acquisition_control dut (
        .clk(clk),
        .rst_b(rst_b),
        .reg_req(reg_req),
        .rd_data(rd_data),
        .acq_running(acq_running),
        .active_record(active_record),
        .pixel_tick(pixel_tick),
        .frame_done(frame_done),
        .xenon_fire(xenon_fire),
        .lamp_flash(lamp_flash),
        .sequencer_doze_signal(doze),
        .bin_enable(bin_enable),
        .record_a_subsample(record_a_subsample)
    );

    // Verdict and end of run, shared by the main sequence and the watchdog
    task automatic finish_test();
        if (num_errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bus cycles: strobe held exactly one cycle, dropped at the sampling edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        reg_req <= '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        exp_q.push_back(e);
        @(posedge clk);
        reg_req <= '0;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Tick count over a window that is a multiple of every division
    task automatic meas(input int d);
        logic [15:0] n;
        n = 16'h0000;
        cyc(4);
        repeat (32) begin
            @(negedge clk);
            if (pixel_tick === 1'b1)
                n++;
        end
        chk(n, 16'(32 / d));
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic int dv(input logic [1:0] c);
        return (c == 2'h1) ? 2 : ((c == 2'h2) ? 4 : 1);
    endfunction

    // Read data stands only in the cycle after the strobe, so look there
    always @(posedge clk) begin
        rd_v <= reg_req.rd;
    end

    always @(negedge clk) begin
        if (rd_v)
            chk(rd_data, exp_q.pop_front());
    end

    // Watchdog, far beyond the several hundred cycles the sequence needs
    initial begin
        #(100 * 20000);
        num_errors++;
        finish_test();
    end

    // Main sequence
    initial begin
        cyc(4);
        rst_b <= 1'b1;
        cyc(3);
        rd(sensor_acq_pkg::OFF_CTRL, 16'h0000);
        rd(sensor_acq_pkg::OFF_ACQ, 16'h0000);
        rd(sensor_acq_pkg::OFF_GLB, 16'h0000);
        rd(8'h10, 16'h0000);
        wr(sensor_acq_pkg::OFF_CTRL, 16'h7fc0);
        rd(sensor_acq_pkg::OFF_CTRL, 16'h0000);
        wr(sensor_acq_pkg::OFF_ACQ, 16'hffff);
        rd(sensor_acq_pkg::OFF_ACQ, sensor_acq_pkg::ACQ_MASK);
        // Random global settings; lamp is not tied to frames, so it follows at once
        repeat (8) begin
            seed = lfsr(seed);
            wr(sensor_acq_pkg::OFF_GLB, seed[15:0]);
            @(negedge clk);
            chk({15'h0, lamp_flash}, {15'h0, seed[0]});
            chk({14'h0, record_a_subsample}, {14'h0, seed[5:4]});
            rd(sensor_acq_pkg::OFF_GLB, seed[15:0] & sensor_acq_pkg::GLB_MASK);
        end
        wr(sensor_acq_pkg::OFF_ACQ, 16'h0000);
        cyc(3);
        @(negedge clk);
        chk({15'h0, doze}, 16'h0000);
        // Every divider code in idle, record A and record B
        wr(sensor_acq_pkg::OFF_GLB, 16'h0004);
        for (int i = 0; i < 4; i++) begin
            da = i[1:0];
            db = da + 2'h1;
            di = da + 2'h2;
            wr(sensor_acq_pkg::OFF_ACQ, {7'h0, 1'b1, di, da, db, 2'h0});
            meas(dv(di));
            chk({15'h0, doze}, 16'h0001);
            wr(sensor_acq_pkg::OFF_CTRL, 16'h0011);
            meas(dv(da));
            chk({15'h0, doze}, 16'h0000);
            chk({15'h0, bin_enable}, 16'h0001);
            chk({15'h0, active_record}, 16'h0000);
            rd(sensor_acq_pkg::OFF_STAT, {11'h000, 1'b0, da, 1'b0, 1'b1});
            wr(sensor_acq_pkg::OFF_CTRL, 16'h001b);
            meas(dv(db));
            chk({15'h0, active_record}, 16'h0001);
            chk({15'h0, bin_enable}, 16'h0000);
            rd(sensor_acq_pkg::OFF_STAT, {11'h000, 1'b0, db, 1'b1, 1'b1});
            wr(sensor_acq_pkg::OFF_CTRL, 16'h0010);
            cyc(2);
            @(negedge clk);
            chk({15'h0, acq_running}, 16'h0000);
        end
        // Xenon fires only with enable and the arm of the started record
        foreach (xtab[j]) begin
            wr(sensor_acq_pkg::OFF_ACQ, xtab[j][47:32]);
            wr(sensor_acq_pkg::OFF_CTRL, xtab[j][31:16]);
            @(negedge clk);
            chk({15'h0, xenon_fire}, xtab[j][15:0]);
            wr(sensor_acq_pkg::OFF_CTRL, 16'h0010);
            cyc(3);
        end
        // Slow stop drains the frame before going idle
        wr(sensor_acq_pkg::OFF_ACQ, 16'h0000);
        wr(sensor_acq_pkg::OFF_CTRL, 16'h0001);
        cyc(3);
        wr(sensor_acq_pkg::OFF_CTRL, 16'h0000);
        @(negedge clk);
        chk({15'h0, acq_running}, 16'h0001);
        for (k = 0; k < 300 && frame_done !== 1'b1; k++)
            @(negedge clk);
        // The frame began five cycles before the stop was taken
        chk(16'(k), 16'(sensor_acq_pkg::FRAME_TICKS - 16'h0005));
        @(negedge clk);
        chk({15'h0, acq_running}, 16'h0000);
        // Slow restart into record B waits for the frame end as well
        wr(sensor_acq_pkg::OFF_CTRL, 16'h0001);
        cyc(3);
        wr(sensor_acq_pkg::OFF_CTRL, 16'h000b);
        @(negedge clk);
        chk({15'h0, active_record}, 16'h0000);
        for (k = 0; k < 300 && frame_done !== 1'b1; k++)
            @(negedge clk);
        chk(16'(k), 16'(sensor_acq_pkg::FRAME_TICKS - 16'h0005));
        @(negedge clk);
        chk({15'h0, acq_running}, 16'h0001);
        chk({15'h0, active_record}, 16'h0001);
        wr(sensor_acq_pkg::OFF_CTRL, 16'h0010);
        cyc(2);
        // Soft reset clears control only; dividers as advised for preview and snapshot
        wr(sensor_acq_pkg::OFF_ACQ, 16'h0190);
        wr(sensor_acq_pkg::OFF_CTRL, 16'h0001);
        cyc(3);
        wr(sensor_acq_pkg::OFF_CTRL, 16'h8000);
        cyc(2);
        @(negedge clk);
        chk({15'h0, acq_running}, 16'h0000);
        chk({15'h0, doze}, 16'h0001);
        rd(sensor_acq_pkg::OFF_CTRL, 16'h0000);
        rd(sensor_acq_pkg::OFF_ACQ, 16'h0190);
        rd(sensor_acq_pkg::OFF_GLB, 16'h0004);
        meas(4);
        cyc(4);
        finish_test();
    end
endmodule
